// ==== misc_regs.svh ====
// Purpose: offsets, field positions, reset values of the interrupt block
// Assumes: 32-bit register words, byte addresses
// Notes: included by the misc_irq module only
`ifndef MISC_REGS_SVH
`define MISC_REGS_SVH
`define MISC_OFS_STATUS 8'h10
`define MISC_OFS_MASK 8'h14
`define MISC_OFS_GATE 8'h18
`define MISC_OFS_EARLY_CFG 8'h30
`define MISC_MASK_RESET 32'h00000000
`define MISC_GATE_RESET 1'h0
`define MISC_MASK_USED 32'h03ffffff
`define MISC_MASK_HOLE 32'h000e0000
`define MISC_BIT_RX_GOOD 0
`define MISC_BIT_RX_DESC 1
`define MISC_BIT_RX_FAIL 2
`define MISC_BIT_RX_EARLY 3
`define MISC_BIT_RX_IDLE 4
`define MISC_BIT_RX_OVF 5
`define MISC_BIT_TX_DONE 6
`define MISC_BIT_TX_DESC 7
`define MISC_BIT_UPPER_SUM 15
`define MISC_UPPER_LO 16
`define MISC_UPPER_HI 25
`define MISC_DRAIN_RESET 8'h00
`endif

// ==== misc_pkg.sv ====
// Purpose: types of the interrupt status and mask block
// Assumes: nothing
// Notes: constants live in misc_regs.svh
package misc_pkg;
   typedef enum logic [0:0] {
      misc_early_armed = 1'b0,
      misc_early_spent = 1'b1
   } misc_early_state_t;
endpackage

// ==== misc_early.sv ====
// Purpose: early receive threshold detector, one event per packet
// Assumes: byte counts arrive as pulses with a size
// Notes: threshold zero never fires
`timescale 1ns/1ps
module misc_early #(
   parameter int CW = 12
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   input wire logic soft_reset,
   // receive dma progress
   input wire logic rx_packet_start,
   input wire logic rx_bytes_valid,
   input wire logic [CW-1:0] rx_bytes_count,
   input wire logic [CW-1:0] threshold_bytes,
   // event out
   output logic early_pulse
);
   misc_pkg::misc_early_state_t state;
   logic [CW-1:0] moved;
   logic [CW:0] next_moved;
   logic hit;

   assign next_moved = {1'b0, moved} + {1'b0, rx_bytes_count};
   assign hit = rx_bytes_valid && (threshold_bytes != '0) &&
                (next_moved >= {1'b0, threshold_bytes});

   // ----------------------------------------------------------------
   // byte count of the current packet
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         moved <= '0;
      end else if (soft_reset || rx_packet_start) begin
         moved <= '0;
      end else if (rx_bytes_valid) begin
         moved <= next_moved[CW] ? '1 : next_moved[CW-1:0];
      end
   end

   // ----------------------------------------------------------------
   // fire once then wait for next packet
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state <= misc_pkg::misc_early_armed;
         early_pulse <= 1'b0;
      end else begin
         early_pulse <= 1'b0;
         if (soft_reset || rx_packet_start) begin
            state <= misc_pkg::misc_early_armed;
         end else begin
            unique case (state)
               misc_pkg::misc_early_armed: begin
                  if (hit) begin
                     state <= misc_pkg::misc_early_spent;
                     early_pulse <= 1'b1;
                  end
               end
               misc_pkg::misc_early_spent: begin
                  state <= misc_pkg::misc_early_spent;
               end
            endcase
         end
      end
   end
endmodule

// ==== misc_irq.sv ====
// Purpose: interrupt status, mask and gate of the ethernet controller
// Assumes: event inputs are one-cycle pulses from the engines
// Notes: status is cleared by reading it; set wins over that clear
`timescale 1ns/1ps
`include "misc_regs.svh"
module misc_irq #(
   parameter int CW = 12
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   input wire logic soft_reset,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   // transmit events
   input wire logic tx_descriptor_event,
   input wire logic tx_packet_done,
   input wire logic tx_packet_failed,
   input wire logic tx_went_idle,
   input wire logic tx_fifo_underflow,
   input wire logic tx_reset_done,
   // receive events
   input wire logic rx_descriptor_event,
   input wire logic rx_packet_good,
   input wire logic rx_packet_failed,
   input wire logic rx_fifo_overflow,
   input wire logic rx_running,
   input wire logic rx_status_fifo_overflow,
   input wire logic rx_reset_done,
   // receive dma progress
   input wire logic rx_packet_start,
   input wire logic rx_bytes_valid,
   input wire logic [CW-1:0] rx_bytes_count,
   // other sources
   input wire logic statistics_service,
   input wire logic software_raised_irq,
   input wire logic power_wake_event,
   input wire logic phy_event,
   input wire logic parity_fault_detected,
   input wire logic system_fault_signalled,
   input wire logic master_abort_received,
   input wire logic target_abort_received,
   // interrupt line
   output logic irq
);
   logic [31:0] interrupt_status;
   logic [31:0] interrupt_mask;
   logic global_irq_gate;
   logic [7:0] rx_drain_threshold;
   logic rx_running_d;
   logic early_pulse;
   logic [31:0] events;
   logic [31:0] next_status;
   logic [31:0] status_view;
   logic [CW-1:0] threshold_bytes;
   logic wr_mask;
   logic wr_gate;
   logic wr_early;
   logic rd_status;

   assign wr_mask = reg_write && (reg_addr == `MISC_OFS_MASK);
   assign wr_gate = reg_write && (reg_addr == `MISC_OFS_GATE);
   assign wr_early = reg_write && (reg_addr == `MISC_OFS_EARLY_CFG);
   assign rd_status = reg_read && (reg_addr == `MISC_OFS_STATUS);
   // threshold counts in units of eight bytes
   assign threshold_bytes = CW'({rx_drain_threshold, 3'b000});

   // ----------------------------------------------------------------
   // early threshold detector
   // ----------------------------------------------------------------
   misc_early #(
      .CW(CW)
   ) u_early (
      .clk(clk),
      .resetn(resetn),
      .soft_reset(soft_reset),
      .rx_packet_start(rx_packet_start),
      .rx_bytes_valid(rx_bytes_valid),
      .rx_bytes_count(rx_bytes_count),
      .threshold_bytes(threshold_bytes),
      .early_pulse(early_pulse)
   );

   // ----------------------------------------------------------------
   // event collection
   // ----------------------------------------------------------------
   always_comb begin
      events = 32'h00000000;
      events[`MISC_BIT_RX_GOOD] = rx_packet_good;
      events[`MISC_BIT_RX_DESC] = rx_descriptor_event;
      events[`MISC_BIT_RX_FAIL] = rx_packet_failed;
      events[`MISC_BIT_RX_EARLY] = early_pulse;
      events[`MISC_BIT_RX_IDLE] = rx_running_d && !rx_running;
      events[`MISC_BIT_RX_OVF] = rx_fifo_overflow;
      events[`MISC_BIT_TX_DONE] = tx_packet_done;
      events[`MISC_BIT_TX_DESC] = tx_descriptor_event;
      events[8] = tx_packet_failed;
      events[9] = tx_went_idle;
      events[10] = tx_fifo_underflow;
      events[11] = statistics_service;
      events[12] = software_raised_irq;
      events[13] = power_wake_event;
      events[14] = phy_event;
      events[16] = rx_status_fifo_overflow;
      events[20] = target_abort_received;
      events[21] = master_abort_received;
      events[22] = system_fault_signalled;
      events[23] = parity_fault_detected;
      events[24] = rx_reset_done;
      events[25] = tx_reset_done;
   end

   // read clears, new events win; mask plays no part here
   always_comb begin
      next_status = (rd_status ? 32'h00000000 : interrupt_status)
                    | events;
      next_status[31:26] = 6'h00;
      next_status[19:17] = 3'h0;
      next_status[`MISC_BIT_UPPER_SUM] =
         |next_status[`MISC_UPPER_HI:`MISC_UPPER_LO];
   end

   always_comb begin
      status_view = interrupt_status;
      status_view[`MISC_BIT_UPPER_SUM] =
         |interrupt_status[`MISC_UPPER_HI:`MISC_UPPER_LO];
   end

   // ----------------------------------------------------------------
   // idle edge tracking
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rx_running_d <= 1'b0;
      end else begin
         rx_running_d <= rx_running;
      end
   end

   // ----------------------------------------------------------------
   // status register
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         interrupt_status <= 32'h00000000;
      end else if (soft_reset) begin
         interrupt_status <= 32'h00000000;
      end else begin
         interrupt_status <= next_status;
      end
   end

   // ----------------------------------------------------------------
   // mask, gate and threshold registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         interrupt_mask <= `MISC_MASK_RESET;
      end else if (soft_reset) begin
         interrupt_mask <= `MISC_MASK_RESET;
      end else if (wr_mask) begin
         interrupt_mask <= reg_wdata & `MISC_MASK_USED
                           & ~`MISC_MASK_HOLE;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         global_irq_gate <= `MISC_GATE_RESET;
      end else if (soft_reset) begin
         global_irq_gate <= `MISC_GATE_RESET;
      end else if (wr_gate) begin
         global_irq_gate <= reg_wdata[0];
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rx_drain_threshold <= `MISC_DRAIN_RESET;
      end else if (soft_reset) begin
         rx_drain_threshold <= `MISC_DRAIN_RESET;
      end else if (wr_early) begin
         rx_drain_threshold <= reg_wdata[7:0];
      end
   end

   // ----------------------------------------------------------------
   // read data, one cycle after the strobe
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_read) begin
         unique case (reg_addr)
            `MISC_OFS_STATUS: reg_rdata <= status_view;
            `MISC_OFS_MASK: reg_rdata <= interrupt_mask;
            `MISC_OFS_GATE: reg_rdata <= {31'h00000000, global_irq_gate};
            `MISC_OFS_EARLY_CFG: reg_rdata <= {24'h000000,
                                               rx_drain_threshold};
            default: reg_rdata <= 32'h00000000;
         endcase
      end else begin
         reg_rdata <= 32'h00000000;
      end
   end

   // ----------------------------------------------------------------
   // interrupt line
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irq <= 1'b0;
      end else if (soft_reset) begin
         irq <= 1'b0;
      end else begin
         irq <= global_irq_gate && |(next_status & interrupt_mask);
      end
   end
endmodule

// ==== misc_irq_assertions.sv ====
// Purpose: assertions on the misc_irq ports
// Assumes: read data stand one cycle after the read strobe
// Notes: mask and gate are shadowed from register writes
`timescale 1ns/1ps
module misc_irq_chk (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   input wire logic soft_reset,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [31:0] reg_rdata,
   // events and line
   input wire logic tx_descriptor_event,
   input wire logic rx_fifo_overflow,
   input wire logic rx_packet_good,
   input wire logic rx_running,
   input wire logic irq
);
   logic [31:0] msk;
   logic gt;
   // shadow of mask and gate
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         msk <= 32'h0;
         gt <= 1'b0;
      end else if (soft_reset) begin
         msk <= 32'h0;
         gt <= 1'b0;
      end else if (reg_write && reg_addr == 8'h14) begin
         msk <= reg_wdata & 32'h03f1ffff;
      end else if (reg_write && reg_addr == 8'h18) begin
         gt <= reg_wdata[0];
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn || soft_reset);
   sequence s_rd; !reg_read ##1 reg_read && reg_addr == 8'h10; endsequence
   property p_tx_desc; tx_descriptor_event ##1 s_rd |=> reg_rdata[7];
   endproperty
   a_tx_desc: assert property (p_tx_desc) else $error("bit 7 lost");
   property p_ovf; rx_fifo_overflow ##1 s_rd |=> reg_rdata[5]; endproperty
   a_ovf: assert property (p_ovf) else $error("bit 5 lost");
   property p_idle; $fell(rx_running) ##1 s_rd |=> reg_rdata[4]; endproperty
   a_idle: assert property (p_idle) else $error("bit 4 lost");
   property p_good; rx_packet_good ##1 s_rd |=> reg_rdata[0]; endproperty
   a_good: assert property (p_good) else $error("bit 0 lost");
   property p_mask_rd; reg_read && reg_addr == 8'h14 |=> reg_rdata == msk;
   endproperty
   a_mask_rd: assert property (p_mask_rd) else $error("mask read");
   property p_msk_off; (msk == 32'h0) [*2] |-> !irq; endproperty
   a_msk_off: assert property (p_msk_off) else $error("irq unmasked");
   property p_gate_off; (!gt) [*2] |-> !irq; endproperty
   a_gate_off: assert property (p_gate_off) else $error("irq ungated");
   property p_irq_on; rx_packet_good && msk[0] && gt && !reg_write |=> irq;
   endproperty
   a_irq_on: assert property (p_irq_on) else $error("irq missing");
endmodule
bind misc_irq misc_irq_chk u_chk (.clk, .resetn, .soft_reset, .reg_addr,
   .reg_wdata, .reg_write, .reg_read, .reg_rdata, .tx_descriptor_event,
   .rx_fifo_overflow, .rx_packet_good, .rx_running, .irq);

// ==== misc_host.sv ====
// Purpose: host side that counts interrupt requests
// Assumes: irq is a registered level
// Notes: each rise of the line is one service request
`timescale 1ns/1ps
module misc_host (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // interrupt line
   input wire logic irq,
   output logic [7:0] irq_seen
);
   logic last;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         last <= 1'b0;
         irq_seen <= 8'h00;
      end else begin
         last <= irq;
         if (irq && !last) irq_seen <= irq_seen + 8'h01;
      end
   end
endmodule

// ==== testbench.sv ====
// Purpose: random and corner tests of misc_irq
// Assumes: 40 MHz clock, read data one cycle after the strobe
// Notes: event inputs are driven as one-cycle pulses
`timescale 1ns/1ps
module testbench;
   logic clk, resetn, soft_reset, reg_write, reg_read, irq, rx_running;
   logic rx_packet_start, rx_bytes_valid;
   logic [11:0] rx_bytes_count;
   logic [7:0] reg_addr, irq_seen, hits;
   logic [31:0] reg_wdata, reg_rdata, d, m;
   logic [19:0] ev;
   int bad_count, num_checks, cyc;
   int bmap[20] = '{7, 6, 8, 9, 10, 25, 1, 0, 2, 5, 16, 24, 11, 12, 13, 14,
      23, 22, 21, 20};
   misc_irq #(.CW(12)) u_dut (.clk, .resetn, .soft_reset, .reg_addr,
      .reg_wdata, .reg_write, .reg_read, .reg_rdata,
      .tx_descriptor_event(ev[0]), .tx_packet_done(ev[1]),
      .tx_packet_failed(ev[2]), .tx_went_idle(ev[3]),
      .tx_fifo_underflow(ev[4]), .tx_reset_done(ev[5]),
      .rx_descriptor_event(ev[6]), .rx_packet_good(ev[7]),
      .rx_packet_failed(ev[8]), .rx_fifo_overflow(ev[9]), .rx_running,
      .rx_status_fifo_overflow(ev[10]), .rx_reset_done(ev[11]),
      .rx_packet_start, .rx_bytes_valid, .rx_bytes_count,
      .statistics_service(ev[12]), .software_raised_irq(ev[13]),
      .power_wake_event(ev[14]), .phy_event(ev[15]),
      .parity_fault_detected(ev[16]), .system_fault_signalled(ev[17]),
      .master_abort_received(ev[18]), .target_abort_received(ev[19]),
      .irq);
   misc_host u_host (.clk, .resetn, .irq, .irq_seen);
   function automatic logic [31:0] st_of(int i);
      st_of = 32'h1 << bmap[i];
      if (bmap[i] >= 16) st_of[15] = 1'b1;
   endfunction
   function automatic logic irq_of(int i, logic [31:0] mk, logic g);
      irq_of = g && |(st_of(i) & mk);
   endfunction
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value %0s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         stop_test();
      end
   end
   initial begin
      {resetn, soft_reset, reg_write, reg_read, rx_running} = '0;
      {rx_packet_start, rx_bytes_valid, rx_bytes_count, ev} = '0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      hits = 8'h00;
      void'($urandom(32'hcffd));
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      rd(8'h14);
      chk("mask", 32'h0, d);
      rd(8'h3c);
      chk("unmapped", 32'h0, d);
      wr(8'h14, 32'hffffffff);
      rd(8'h14);
      chk("mask", 32'h03f1ffff, d);
      $display("test registers done");
      for (int k = 0; k < 3; k++) begin
         m = (k == 0) ? 32'h0 : ($urandom() | 32'h1);
         wr(8'h14, m);
         wr(8'h18, {31'h0, k != 1});
         for (int i = 0; i < 20; i++) begin
            @(posedge clk);
            ev[i] <= 1'b1;
            @(posedge clk);
            ev[i] <= 1'b0;
            #1 hits += {7'h0, irq_of(i, m, k != 1)};
            chk("irq", {31'h0, irq_of(i, m, k != 1)}, {31'h0, irq});
            rd(8'h10);
            chk("status", st_of(i), d);
            chk("irq", 32'h0, {31'h0, irq});
            rd(8'h10);
            chk("status", 32'h0, d);
         end
      end
      chk("host", {24'h0, hits}, {24'h0, irq_seen});
      $display("test events done");
      @(posedge clk);
      rx_running <= 1'b1;
      repeat (3) @(posedge clk);
      rx_running <= 1'b0;
      @(posedge clk);
      rd(8'h10);
      chk("status", 32'h10, d);
      $display("test idle done");
      wr(8'h30, 32'h2);
      @(posedge clk);
      rx_packet_start <= 1'b1;
      @(posedge clk);
      rx_packet_start <= 1'b0;
      rx_bytes_valid <= 1'b1;
      rx_bytes_count <= 12'h008;
      repeat (4) @(posedge clk);
      rx_bytes_valid <= 1'b0;
      repeat (2) @(posedge clk);
      rd(8'h10);
      chk("status", 32'h8, d);
      rd(8'h30);
      chk("drain", 32'h2, d);
      // more bytes of the same packet must not fire again
      @(posedge clk);
      rx_bytes_valid <= 1'b1;
      repeat (3) @(posedge clk);
      rx_bytes_valid <= 1'b0;
      repeat (2) @(posedge clk);
      rd(8'h10);
      chk("status", 32'h0, d);
      // a new packet re-arms the detector
      @(posedge clk);
      rx_packet_start <= 1'b1;
      @(posedge clk);
      rx_packet_start <= 1'b0;
      rx_bytes_valid <= 1'b1;
      repeat (2) @(posedge clk);
      rx_bytes_valid <= 1'b0;
      repeat (2) @(posedge clk);
      rd(8'h10);
      chk("status", 32'h8, d);
      $display("test early done");
      rd(8'h18);
      chk("gate", 32'h1, d);
      wr(8'h14, 32'hff);
      @(posedge clk);
      ev[7] <= 1'b1;
      @(posedge clk);
      ev[7] <= 1'b0;
      soft_reset <= 1'b1;
      @(posedge clk);
      soft_reset <= 1'b0;
      rd(8'h14);
      chk("mask", 32'h0, d);
      chk("irq", 32'h0, {31'h0, irq});
      rd(8'h10);
      chk("status", 32'h0, d);
      rd(8'h18);
      chk("gate", 32'h0, d);
      $display("test soft reset done");
      stop_test();
   end
endmodule
